//--- vsvr_pkg.sv
// vsvr_pkg: register map, reset values, timing counts and enums
// for the regulator register bank; assumes a 100 MHz controller clock.
package vsvr_pkg;

    localparam int CLK_NS = 10;

    // register indices
    localparam logic [7:0] REG_STATUS2 = 8'h11;
    localparam logic [7:0] REG_ZONE    = 8'h12;
    localparam logic [7:0] REG_IOUT    = 8'h15;
    localparam logic [7:0] REG_VOUT    = 8'h16;
    localparam logic [7:0] REG_TEMP    = 8'h17;
    localparam logic [7:0] REG_POUT    = 8'h18;
    localparam logic [7:0] REG_SNAP    = 8'h1C;
    localparam logic [7:0] REG_MAX_CURRENT_STRAP  = 8'h21;
    localparam logic [7:0] REG_TLIMIT  = 8'h22;
    localparam logic [7:0] REG_FAST    = 8'h24;
    localparam logic [7:0] REG_SLOW    = 8'h25;
    localparam logic [7:0] REG_BOOT    = 8'h26;
    localparam logic [7:0] REG_CEIL    = 8'h30;
    localparam logic [7:0] REG_TARGET  = 8'h31;
    localparam logic [7:0] REG_PSTATE  = 8'h32;
    localparam logic [7:0] REG_MARGIN  = 8'h33;
    localparam logic [7:0] REG_MVRCFG  = 8'h34;

    // values after reset
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_TELEM   = 8'h01;
    localparam logic [7:0] RST_TLIMIT  = 8'h64;
    localparam logic [7:0] RST_FAST    = 8'h0A;
    localparam logic [7:0] RST_SLOW    = 8'h02;
    localparam logic [7:0] RST_CEIL    = 8'hFB;
    localparam logic [7:0] FULL_SCALE  = 8'hFF;

    // one voltage-code step, and step periods from the ramp rates
    localparam int VID_STEP_UV = 5000;
    localparam logic [7:0] STEP_FAST_CYC = 8'(VID_STEP_UV / int'(RST_FAST) / CLK_NS);
    localparam logic [7:0] STEP_SLOW_CYC = 8'(VID_STEP_UV / int'(RST_SLOW) / CLK_NS);

    // strap settling before the one-time capture
    localparam int STRAP_SETTLE_NS = 1000;
    localparam logic [6:0] STRAP_SETTLE_CYC = 7'(STRAP_SETTLE_NS / CLK_NS);

    // startup-strap resistor index and decoded voltage codes
    localparam logic [2:0] STRAP_10K  = 3'h0;
    localparam logic [2:0] STRAP_25K  = 3'h1;
    localparam logic [2:0] STRAP_45K  = 3'h2;
    localparam logic [2:0] STRAP_70K  = 3'h3;
    localparam logic [2:0] STRAP_95K  = 3'h4;
    localparam logic [2:0] STRAP_125K = 3'h5;
    localparam logic [2:0] STRAP_165K = 3'h6;
    localparam logic [2:0] STRAP_VCC  = 3'h7;
    localparam logic [7:0] BOOT_0V00  = 8'h00;
    localparam logic [7:0] BOOT_0V90  = 8'h83;
    localparam logic [7:0] BOOT_1V00  = 8'h97;
    localparam logic [7:0] BOOT_1V10  = 8'hAB;
    localparam logic [7:0] BOOT_1V20  = 8'hBF;
    localparam logic [7:0] BOOT_1V35  = 8'hDD;
    localparam logic [7:0] BOOT_1V50  = 8'hFB;

    typedef enum logic [1:0] {
        CMD_FAST  = 2'b01,
        CMD_SLOW  = 2'b10,
        CMD_DECAY = 2'b11
    } vsvr_cmd_e;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_BOOT   = 2'b01,
        ST_RUN    = 2'b10
    } vsvr_state_e;

endpackage

//--- vsvr_sync.sv
// vsvr_sync: two-flop synchroniser for a bundle of pin levels
// assumes the inputs are quasi-static or qualified by a synced strobe.
`timescale 1ns/100ps
module vsvr_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } vsvr_sync_s;

    vsvr_sync_s s_ff;
    vsvr_sync_s nxt_s;

    always_comb begin
        nxt_s.s1 = d_i;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q_o = s_ff.s2;
endmodule // vsvr_sync

//--- vsvr_strap_dec.sv
// vsvr_strap_dec: startup-strap resistor index to voltage code
// assumes the index has already been synchronised.
`timescale 1ns/100ps
module vsvr_strap_dec (
    input  wire logic [2:0] strap_i,
    output logic      [7:0] code_o,
    output logic            shutdown_o
);
    import vsvr_pkg::*;

    always_comb begin
        shutdown_o = 1'b0;
        case (strap_i)
            STRAP_10K:  code_o = BOOT_0V00;
            STRAP_25K:  code_o = BOOT_0V90;
            STRAP_45K:  code_o = BOOT_1V00;
            STRAP_70K:  code_o = BOOT_1V10;
            STRAP_95K:  code_o = BOOT_1V20;
            STRAP_125K: code_o = BOOT_1V35;
            STRAP_165K: code_o = BOOT_1V50;
            STRAP_VCC: begin
                code_o     = BOOT_0V00;
                shutdown_o = 1'b1;
            end
            default:    code_o = BOOT_0V00;
        endcase
    end
endmodule // vsvr_strap_dec

//--- vsvr_top.sv
// vsvr_top: register bank of a dual-rail regulator controller
// assumes a frame decoder on mclk_i presents register and command
// accesses; telemetry ADC and straps arrive asynchronously on pins.
//
// Operation
// - current reading full scale equals platform maximum
// - voltage reading differential sense, 8 mV counts
// - temperature in degrees, zero means unsupported
// - power equals voltage times current, 8 bits
// - reading secondary status copies it to snapshot
// - maximum current strapped once, then read-only
// - thermal limit resets 100, hot at limit
// - fast ramp rate read-only, resets 0Ah
// - slow ramp rate read-only, resets 02h
// - ramp to startup voltage, hold until command
// - code above ceiling gets not-supported answer
// - target code register read-write, resets zero
// - power state register read-write, resets zero
// - signed margin steps added to target code
// - per-rail startup voltage strapped, host readable
// - strap resistor decodes to fixed startup voltages
// - aux strap at supply shuts aux rail off
// - aux off selects alternate single address map
// - zone and secondary status read-only, reset zero
// - bus address latched once at startup
`timescale 1ns/100ps
module vsvr_top (
    input  wire logic                mclk_i,
    input  wire logic                reset_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic                reg_aux_i,
    output logic      [7:0]          reg_rdata_o,
    output logic                     reg_valid_o,
    input  wire logic                cmd_valid_i,
    input  wire vsvr_pkg::vsvr_cmd_e cmd_kind_i,
    input  wire logic [7:0]          cmd_code_i,
    output logic                     cmd_ack_o,
    output logic                     cmd_nak_o,
    input  wire logic                adc_valid_i,
    input  wire logic [7:0]          current_raw_i,
    input  wire logic [7:0]          sense_positive_input_i,
    input  wire logic [7:0]          sense_negative_input_i,
    input  wire logic [7:0]          temp_raw_i,
    input  wire logic [7:0]          max_current_strap_i,
    input  wire logic [2:0]          main_startup_strap_i,
    input  wire logic [2:0]          aux_startup_strap_i,
    input  wire logic [3:0]          addr_strap_i,
    input  wire logic [7:0]          status2_i,
    input  wire logic [7:0]          zone_i,
    output logic                     regulator_hot_indication_o,
    output logic      [7:0]          voltage_code_o,
    output logic      [7:0]          aux_voltage_code_o,
    output logic                     aux_shutdown_o,
    output logic                     aux_present_o,
    output logic      [3:0]          bus_address_o,
    output logic      [3:0]          aux_address_o,
    output logic                     straps_ready_o
);
    import vsvr_pkg::*;

    typedef struct packed {
        vsvr_state_e state;
        logic [6:0]  settle_cnt;
        logic        adc_prev;
        logic [7:0]  icc_max;
        logic [7:0]  boot_main;
        logic [7:0]  boot_aux;
        logic        aux_off;
        logic [3:0]  addr_main;
        logic [3:0]  addr_aux;
        logic [7:0]  status2;
        logic [7:0]  zone;
        logic [7:0]  snap;
        logic [7:0]  iout;
        logic [7:0]  vout;
        logic [7:0]  temp;
        logic [7:0]  pout;
        logic [7:0]  tlimit;
        logic [7:0]  ceil;
        logic [7:0]  target;
        logic [7:0]  pstate;
        logic [7:0]  margin;
        logic [7:0]  mvrcfg;
        logic        cmd_seen;
        logic        slow_sel;
        logic [7:0]  out_code;
        logic [7:0]  step_cnt;
        logic [3:0]  div_cnt;
        logic [15:0] div_num;
        logic [7:0]  div_rem;
        logic [7:0]  div_q;
        logic        hot;
        logic        ack;
        logic        nak;
        logic        rvalid;
        logic [7:0]  rdata;
    } vsvr_state_s;

    vsvr_state_s s_ff;
    vsvr_state_s nxt_s;

    logic [50:0] pin_sync;
    logic        adc_vld_sync;
    logic [7:0]  cur_sync;
    logic [7:0]  sp_sync;
    logic [7:0]  sn_sync;
    logic [7:0]  temp_sync;
    logic [7:0]  icc_sync;
    logic [2:0]  bootm_sync;
    logic [2:0]  boota_sync;
    logic [3:0]  addr_sync;
    logic [7:0]  boot_main_code;
    logic [7:0]  boot_aux_code;
    logic        aux_shut;
    logic        blocked;
    logic [7:0]  goal;
    logic [9:0]  margin_sum;

    vsvr_sync #(.W(51)) u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .d_i     ({adc_valid_i, current_raw_i, sense_positive_input_i, sense_negative_input_i,
                   temp_raw_i, max_current_strap_i, main_startup_strap_i, aux_startup_strap_i,
                   addr_strap_i}),
        .q_o     (pin_sync)
    );

    assign {adc_vld_sync, cur_sync, sp_sync, sn_sync, temp_sync, icc_sync, bootm_sync,
            boota_sync, addr_sync} = pin_sync;

    vsvr_strap_dec u_dec_main (
        .strap_i    (bootm_sync),
        .code_o     (boot_main_code),
        .shutdown_o ()
    );

    vsvr_strap_dec u_dec_aux (
        .strap_i    (boota_sync),
        .code_o     (boot_aux_code),
        .shutdown_o (aux_shut)
    );

    // accesses to a removed aux rail are not answered with data
    assign blocked = reg_aux_i && s_ff.aux_off;

    // target plus signed margin, clamped to the code range
    assign margin_sum = {2'b00, s_ff.target} + {{2{s_ff.margin[7]}}, s_ff.margin};

    always_comb begin
        if (!s_ff.cmd_seen) begin
            goal = s_ff.boot_main;
        end else if (margin_sum[9]) begin
            goal = 8'h00;
        end else if (margin_sum[8]) begin
            goal = FULL_SCALE;
        end else begin
            goal = margin_sum[7:0];
        end
    end

    always_comb begin
        logic [8:0]  rem9;
        logic [15:0] prod;
        rem9       = '0;
        prod       = '0;
        nxt_s      = s_ff;
        nxt_s.ack  = 1'b0;
        nxt_s.nak  = 1'b0;
        nxt_s.rvalid = reg_rd_i;
        nxt_s.adc_prev = adc_vld_sync;
        nxt_s.status2 = status2_i;
        nxt_s.zone = zone_i;
        nxt_s.hot = (s_ff.temp != 8'h00) && (s_ff.temp >= s_ff.tlimit);

        // one-time strap capture after the pins settle
        case (s_ff.state)
            ST_SETTLE: begin
                if (s_ff.settle_cnt == 7'h00) begin
                    nxt_s.icc_max   = icc_sync;
                    nxt_s.boot_main = boot_main_code;
                    nxt_s.boot_aux  = boot_aux_code;
                    nxt_s.aux_off   = aux_shut;
                    nxt_s.addr_main = aux_shut ? addr_sync : {addr_sync[2:0], 1'b0};
                    nxt_s.addr_aux  = {addr_sync[2:0], 1'b1};
                    nxt_s.state     = ST_BOOT;
                end else begin
                    nxt_s.settle_cnt = s_ff.settle_cnt - 7'h01;
                end
            end
            ST_BOOT, ST_RUN: begin
                // one code step per period toward the goal
                if (s_ff.step_cnt != 8'h00) begin
                    nxt_s.step_cnt = s_ff.step_cnt - 8'h01;
                end else if (s_ff.out_code != goal) begin
                    nxt_s.out_code = (s_ff.out_code < goal) ? s_ff.out_code + 8'h01
                                                            : s_ff.out_code - 8'h01;
                    nxt_s.step_cnt = s_ff.slow_sel ? STEP_SLOW_CYC - 8'h01
                                                   : STEP_FAST_CYC - 8'h01;
                end
            end
            default: begin
                nxt_s.state = ST_SETTLE;
            end
        endcase

        // telemetry sample on the synced strobe edge
        if (adc_vld_sync && !s_ff.adc_prev && s_ff.div_cnt == 4'h0) begin
            nxt_s.vout = (sp_sync > sn_sync) ? sp_sync - sn_sync : 8'h00;
            nxt_s.temp = temp_sync;
            if (cur_sync >= s_ff.icc_max) begin
                nxt_s.iout = FULL_SCALE;
                prod       = nxt_s.vout * FULL_SCALE;
                nxt_s.pout = prod[15:8];
            end else begin
                nxt_s.div_num = cur_sync * FULL_SCALE;
                nxt_s.div_rem = nxt_s.div_num[15:8];
                nxt_s.div_q   = 8'h00;
                nxt_s.div_cnt = 4'h8;
            end
        end else if (s_ff.div_cnt != 4'h0) begin
            // restoring long division by the platform maximum
            rem9 = {s_ff.div_rem, s_ff.div_num[3'(s_ff.div_cnt - 4'h1)]};
            if (rem9 >= {1'b0, s_ff.icc_max}) begin
                rem9 = rem9 - {1'b0, s_ff.icc_max};
                nxt_s.div_q = {s_ff.div_q[6:0], 1'b1};
            end else begin
                nxt_s.div_q = {s_ff.div_q[6:0], 1'b0};
            end
            nxt_s.div_rem = rem9[7:0];
            nxt_s.div_cnt = s_ff.div_cnt - 4'h1;
            if (s_ff.div_cnt == 4'h1) begin
                nxt_s.iout = nxt_s.div_q;
                prod       = s_ff.vout * nxt_s.div_q;
                nxt_s.pout = prod[15:8];
            end
        end

        // host writes; read-only indices fall through untouched
        if (reg_wr_i && !blocked) begin
            case (reg_addr_i)
                REG_TLIMIT: nxt_s.tlimit = reg_wdata_i;
                REG_CEIL:   nxt_s.ceil   = reg_wdata_i;
                REG_TARGET: nxt_s.target = reg_wdata_i;
                REG_PSTATE: nxt_s.pstate = reg_wdata_i;
                REG_MARGIN: nxt_s.margin = reg_wdata_i;
                REG_MVRCFG: nxt_s.mvrcfg = reg_wdata_i;
                default:    nxt_s.mvrcfg = s_ff.mvrcfg;
            endcase
        end

        // host reads
        if (reg_rd_i) begin
            if (blocked) begin
                nxt_s.rdata = 8'h00;
            end else begin
                case (reg_addr_i)
                    REG_STATUS2: nxt_s.rdata = s_ff.status2;
                    REG_ZONE:    nxt_s.rdata = s_ff.zone;
                    REG_IOUT:    nxt_s.rdata = s_ff.iout;
                    REG_VOUT:    nxt_s.rdata = s_ff.vout;
                    REG_TEMP:    nxt_s.rdata = s_ff.temp;
                    REG_POUT:    nxt_s.rdata = s_ff.pout;
                    REG_SNAP:    nxt_s.rdata = s_ff.snap;
                    REG_MAX_CURRENT_STRAP:  nxt_s.rdata = s_ff.icc_max;
                    REG_TLIMIT:  nxt_s.rdata = s_ff.tlimit;
                    REG_FAST:    nxt_s.rdata = RST_FAST;
                    REG_SLOW:    nxt_s.rdata = RST_SLOW;
                    REG_BOOT:    nxt_s.rdata = reg_aux_i ? s_ff.boot_aux : s_ff.boot_main;
                    REG_CEIL:    nxt_s.rdata = s_ff.ceil;
                    REG_TARGET:  nxt_s.rdata = s_ff.target;
                    REG_PSTATE:  nxt_s.rdata = s_ff.pstate;
                    REG_MARGIN:  nxt_s.rdata = s_ff.margin;
                    REG_MVRCFG:  nxt_s.rdata = s_ff.mvrcfg;
                    default:     nxt_s.rdata = 8'h00;
                endcase
                if (reg_addr_i == REG_STATUS2) begin
                    nxt_s.snap = s_ff.status2;
                end
            end
        end

        // voltage-change commands, checked against the ceiling
        if (cmd_valid_i) begin
            nxt_s.ack = 1'b1;
            if (cmd_code_i > s_ff.ceil) begin
                nxt_s.nak = 1'b1;
            end else begin
                nxt_s.target   = cmd_code_i;
                nxt_s.cmd_seen = 1'b1;
                nxt_s.slow_sel = (cmd_kind_i != CMD_FAST);
                if (s_ff.state != ST_SETTLE) begin
                    nxt_s.state = ST_RUN;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s_ff            <= '0;
            s_ff.state      <= ST_SETTLE;
            s_ff.settle_cnt <= STRAP_SETTLE_CYC;
            s_ff.iout       <= RST_TELEM;
            s_ff.vout       <= RST_TELEM;
            s_ff.temp       <= RST_TELEM;
            s_ff.pout       <= RST_TELEM;
            s_ff.tlimit     <= RST_TLIMIT;
            s_ff.ceil       <= RST_CEIL;
            s_ff.icc_max    <= RST_ZERO;
            s_ff.target     <= RST_ZERO;
            s_ff.pstate     <= RST_ZERO;
            s_ff.margin     <= RST_ZERO;
            s_ff.mvrcfg     <= RST_ZERO;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reg_rdata_o                = s_ff.rdata;
    assign reg_valid_o                = s_ff.rvalid;
    assign cmd_ack_o                  = s_ff.ack;
    assign cmd_nak_o                  = s_ff.nak;
    assign regulator_hot_indication_o = s_ff.hot;
    assign voltage_code_o             = s_ff.out_code;
    assign aux_voltage_code_o         = s_ff.aux_off ? 8'h00 : s_ff.boot_aux;
    assign aux_shutdown_o             = s_ff.aux_off;
    assign aux_present_o              = (s_ff.state != ST_SETTLE) && !s_ff.aux_off;
    assign bus_address_o              = s_ff.addr_main;
    assign aux_address_o              = s_ff.addr_aux;
    assign straps_ready_o             = (s_ff.state != ST_SETTLE);

    // checks
    logic [15:0] chk_prod;
    assign chk_prod = s_ff.vout * s_ff.iout;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    a_ceiling_nak: assert property (cmd_valid_i && (cmd_code_i > s_ff.ceil)
        |=> cmd_ack_o && cmd_nak_o && $stable(s_ff.target)) else $error("code above ceiling not refused");
    a_target_load: assert property (cmd_valid_i && (cmd_code_i <= s_ff.ceil)
        |=> !cmd_nak_o && s_ff.target == $past(cmd_code_i)) else $error("target code not loaded");
    a_snapshot_copy: assert property (reg_rd_i && !blocked && reg_addr_i == REG_STATUS2
        |=> s_ff.snap == $past(s_ff.status2) && reg_valid_o) else $error("snapshot not copied");
    a_strap_frozen: assert property (straps_ready_o && $past(straps_ready_o)
        |-> $stable(s_ff.icc_max) && $stable(bus_address_o) && $stable(s_ff.boot_main))
        else $error("strapped value changed");
    a_ro_ignored: assert property (reg_wr_i && reg_addr_i == REG_MAX_CURRENT_STRAP && straps_ready_o
        ##2 reg_rd_i && reg_addr_i == REG_MAX_CURRENT_STRAP && !blocked |=> reg_rdata_o == $past(s_ff.icc_max, 3))
        else $error("read-only register written");
    a_hot_level: assert property (s_ff.temp != 8'h00 && s_ff.temp >= s_ff.tlimit && $stable(s_ff.temp)
        |=> regulator_hot_indication_o) else $error("hot indication missing");
    a_power_prod: assert property ($changed(s_ff.pout) |-> s_ff.pout == chk_prod[15:8])
        else $error("power is not voltage times current");
    a_boot_hold: assert property (!s_ff.cmd_seen && straps_ready_o && voltage_code_o == s_ff.boot_main
        |=> voltage_code_o == s_ff.boot_main) else $error("startup voltage not held");
    a_ramp_step: assert property ($changed(voltage_code_o) |=> $stable(voltage_code_o) [*8])
        else $error("ramp stepped too fast");
    a_aux_off: assert property (aux_shutdown_o |-> aux_voltage_code_o == 8'h00 && !aux_present_o
        && bus_address_o == $past(addr_sync, 1)) else $error("aux rail not removed");

    c_nak_seen: cover property (cmd_nak_o);
    c_snap_read: cover property (reg_rd_i && reg_addr_i == REG_STATUS2 ##1 reg_valid_o);
    c_hot_seen: cover property (regulator_hot_indication_o);
    c_boot_reached: cover property (straps_ready_o && voltage_code_o == s_ff.boot_main
        && s_ff.boot_main != 8'h00);
endmodule // vsvr_top

//--- vsvr_host.sv
// vsvr_host: host side driving register reads, writes and voltage commands
// assumes a free-running mclk_i; drives only on falling edges.
`timescale 1ns/100ps
module vsvr_host (
    input  wire logic                mclk_i,
    input  wire logic                reg_valid_i,
    input  wire logic [7:0]          reg_rdata_i,
    input  wire logic                cmd_ack_i,
    input  wire logic                cmd_nak_i,
    output logic      [7:0]          addr_o,
    output logic      [7:0]          wdata_o,
    output logic                     wr_o,
    output logic                     rd_o,
    output logic                     aux_o,
    output logic                     cmd_valid_o,
    output vsvr_pkg::vsvr_cmd_e      kind_o,
    output logic      [7:0]          code_o
);
    import vsvr_pkg::*;
    initial begin
        {addr_o, wdata_o, wr_o, rd_o, aux_o, cmd_valid_o, code_o} = '0;
        kind_o = CMD_FAST;
    end
    // released data shows the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
        addr_o = ~a;
    endtask
    task automatic rd(input logic [7:0] a, input logic x, output logic [7:0] d);
        int n;
        @(negedge mclk_i);
        addr_o = a;
        aux_o = x;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        n = 0;
        while (reg_valid_i !== 1'b1 && n < 4) begin
            @(negedge mclk_i);
            n++;
        end
        d = (reg_valid_i === 1'b1) ? reg_rdata_i : 8'hXX;
        aux_o = 1'b0;
    endtask
    // code may exceed the ceiling on purpose to provoke a refusal
    task automatic cmd(input vsvr_cmd_e k, input logic [7:0] c, output logic ack, output logic nak);
        int n;
        @(negedge mclk_i);
        kind_o = k;
        code_o = c;
        cmd_valid_o = 1'b1;
        @(negedge mclk_i);
        cmd_valid_o = 1'b0;
        code_o = ~c;
        n = 0;
        while (cmd_ack_i !== 1'b1 && n < 4) begin
            @(negedge mclk_i);
            n++;
        end
        ack = cmd_ack_i;
        nak = cmd_nak_i;
    endtask
endmodule // vsvr_host

//--- vsvr_tb.sv
// vsvr_tb: self-checking bench for the regulator register bank
// assumes vsvr_top and vsvr_host; inputs change on falling edges.
`timescale 1ns/100ps
module tb;
    import vsvr_pkg::*;
    logic mclk_i = 0, reset_i = 1, adc_valid_i = 0, reg_wr_i, reg_rd_i, reg_aux_i, cmd_valid_i;
    logic [7:0] reg_addr_i, reg_wdata_i, cmd_code_i, current_raw_i = 8'h9C, temp_raw_i = 8'h64;
    logic [7:0] sense_positive_input_i = 8'h90, sense_negative_input_i = 8'h10, status2_i = 8'h00, zone_i = 8'h00;
    logic [7:0] max_current_strap_i = 8'h9C, reg_rdata_o, voltage_code_o, aux_voltage_code_o;
    logic [2:0] main_startup_strap_i = STRAP_25K, aux_startup_strap_i = STRAP_125K;
    logic [3:0] addr_strap_i = 4'h3, bus_address_o, aux_address_o;
    logic reg_valid_o, cmd_ack_o, cmd_nak_o, regulator_hot_indication_o, aux_shutdown_o, aux_present_o, straps_ready_o;
    logic a, k;
    vsvr_cmd_e cmd_kind_i;
    int checked = 0, miscompares = 0, cyc = 0;
    localparam logic [7:0] RA [16] = '{8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1C, 8'h21,
                                       8'h22, 8'h24, 8'h25, 8'h26, 8'h30, 8'h31, 8'h32, 8'h33};
    localparam logic [7:0] RV [16] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
                                       8'h64, 8'h0A, 8'h02, 8'h00, 8'hFB, 8'h00, 8'h00, 8'h00};
    localparam vsvr_cmd_e KD [3] = '{CMD_FAST, CMD_SLOW, CMD_DECAY};
    always #5 mclk_i = ~mclk_i;
    vsvr_top u_dut (.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_aux_i, .reg_rdata_o,
        .reg_valid_o, .cmd_valid_i, .cmd_kind_i, .cmd_code_i, .cmd_ack_o, .cmd_nak_o, .adc_valid_i, .current_raw_i,
        .sense_positive_input_i, .sense_negative_input_i, .temp_raw_i, .max_current_strap_i, .main_startup_strap_i,
        .aux_startup_strap_i, .addr_strap_i, .status2_i, .zone_i, .regulator_hot_indication_o, .voltage_code_o,
        .aux_voltage_code_o, .aux_shutdown_o, .aux_present_o, .bus_address_o, .aux_address_o, .straps_ready_o);
    vsvr_host u_host (.mclk_i, .reg_valid_i(reg_valid_o), .reg_rdata_i(reg_rdata_o), .cmd_ack_i(cmd_ack_o),
        .cmd_nak_i(cmd_nak_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .aux_o(reg_aux_i), .cmd_valid_o(cmd_valid_i), .kind_o(cmd_kind_i), .code_o(cmd_code_i));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] ad, input logic x, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(ad, x, d);
        chk($sformatf("reg %h", ad), e, d);
    endtask
    task automatic rst();
        @(negedge mclk_i);
        reset_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        reset_i = 1'b0;
    endtask
    task automatic wt(input logic [7:0] e);
        for (int n = 0; n < 9000 && voltage_code_o !== e; n++) @(negedge mclk_i);
        chk("voltage_code", e, voltage_code_o);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge mclk_i);
        reset_i = 1'b0;
        foreach (RA[i]) rc(RA[i], 1'b0, RV[i]);
        u_host.wr(REG_FAST, 8'hFF);
        rc(REG_FAST, 1'b0, RST_FAST);
        rc(8'h40, 1'b0, 8'h00);
        u_host.wr(REG_TLIMIT, 8'h50);
        rc(REG_TLIMIT, 1'b0, 8'h50);
        wait (straps_ready_o === 1'b1);
        rc(REG_MAX_CURRENT_STRAP, 1'b0, 8'h9C);
        u_host.wr(REG_MAX_CURRENT_STRAP, 8'h11);
        rc(REG_MAX_CURRENT_STRAP, 1'b0, 8'h9C);
        rc(REG_BOOT, 1'b0, BOOT_0V90);
        rc(REG_BOOT, 1'b1, BOOT_1V35);
        chk("bus_address", 8'h06, {4'h0, bus_address_o});
        chk("aux_address", 8'h07, {4'h0, aux_address_o});
        chk("aux_code", BOOT_1V35, aux_voltage_code_o);
        wt(BOOT_0V90);
        u_host.wr(REG_CEIL, 8'hA0);
        foreach (KD[i]) begin
            u_host.cmd(KD[i], 8'hA1, a, k);
            chk("cmd_nak", 8'h01, {7'h00, k});
        end
        rc(REG_TARGET, 1'b0, 8'h00);
        u_host.cmd(CMD_FAST, 8'hA0, a, k);
        chk("cmd_ack", 8'h02, {6'h00, a, k});
        u_host.wr(REG_MARGIN, 8'hFE);
        wt(8'h9E);
        rc(REG_TARGET, 1'b0, 8'hA0);
        u_host.cmd(CMD_SLOW, 8'h9D, a, k);
        wt(8'h9B);
        u_host.wr(REG_PSTATE, 8'h03);
        rc(REG_PSTATE, 1'b0, 8'h03);
        status2_i = 8'h5A;
        zone_i = 8'h3C;
        rc(REG_STATUS2, 1'b0, 8'h5A);
        status2_i = 8'hC3;
        rc(REG_SNAP, 1'b0, 8'h5A);
        rc(REG_ZONE, 1'b0, 8'h3C);
        adc_valid_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        rc(REG_IOUT, 1'b0, FULL_SCALE);
        rc(REG_VOUT, 1'b0, 8'h80);
        rc(REG_TEMP, 1'b0, 8'h64);
        rc(REG_POUT, 1'b0, 8'h7F);
        chk("hot", 8'h01, {7'h00, regulator_hot_indication_o});
        u_host.wr(REG_TLIMIT, 8'h65);
        repeat (3) @(negedge mclk_i);
        chk("hot", 8'h00, {7'h00, regulator_hot_indication_o});
        current_raw_i = 8'h4E;
        adc_valid_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        adc_valid_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        rc(REG_IOUT, 1'b0, 8'h7F);
        rc(REG_POUT, 1'b0, 8'h3F);
        aux_startup_strap_i = STRAP_VCC;
        rst();
        wait (straps_ready_o === 1'b1);
        chk("aux_off", 8'h02, {6'h00, aux_shutdown_o, aux_present_o});
        chk("bus_address", 8'h03, {4'h0, bus_address_o});
        rc(REG_BOOT, 1'b1, 8'h00);
        chk("aux_code", 8'h00, aux_voltage_code_o);
        summarize();
    end
endmodule // tb
